// ### src/pmx_pkg.sv
// pmx_pkg: constants, types and decode helpers for the port-0 pin function mux.
// assumes a single 250 MHz system clock and one register master.
package pmx_pkg;

  // pins handled by this mux, and select field geometry
  localparam int PIN_COUNT      = 23;
  localparam int FIELD_W        = 2;
  localparam int FIELDS_PER_REG = 16;

  // register byte addresses
  localparam logic [31:0] ADDR_SEL_LOW  = 32'he002c000;
  localparam logic [31:0] ADDR_SEL_HIGH = 32'he002c004;
  localparam logic [31:0] ADDR_SEL_BUS  = 32'he002c014;

  // reset values
  localparam logic [31:0] RST_SEL_LOW  = 32'h00000000;
  localparam logic [31:0] RST_SEL_HIGH = 32'h00000000;
  localparam logic [31:0] RST_SEL_BUS  = 32'h00000000;
  localparam logic [31:0] RD_UNMAPPED  = 32'h00000000;

  // select codes
  localparam logic [1:0] CODE_GPIO = 2'h0;
  localparam logic [1:0] CODE_ALT1 = 2'h1;
  localparam logic [1:0] CODE_ALT2 = 2'h2;
  localparam logic [1:0] CODE_ALT3 = 2'h3;

  // every signal a pin can be joined to
  typedef enum logic [5:0] {
    FN_GPIO, FN_RESERVED,
    FN_U0_TXD, FN_U0_RXD,
    FN_PWM1, FN_PWM2, FN_PWM3, FN_PWM4, FN_PWM5, FN_PWM6,
    FN_EXT_INT0, FN_EXT_INT1, FN_EXT_INT2, FN_EXT_INT3,
    FN_I2C_SCL, FN_I2C_SDA,
    FN_T0_CAP0, FN_T0_CAP1, FN_T0_CAP2,
    FN_T0_MAT0, FN_T0_MAT1, FN_T0_MAT2,
    FN_SPI0_SCK, FN_SPI0_MISO, FN_SPI0_MOSI, FN_SPI0_SSEL,
    FN_U1_TXD, FN_U1_RXD, FN_U1_RTS, FN_U1_CTS,
    FN_U1_DSR, FN_U1_DTR, FN_U1_DCD, FN_U1_RI,
    FN_T1_CAP0, FN_T1_CAP1, FN_T1_CAP2, FN_T1_CAP3,
    FN_T1_MAT0, FN_T1_MAT1, FN_T1_MAT2, FN_T1_MAT3,
    FN_SPI1_SCK, FN_SPI1_MISO, FN_SPI1_MOSI, FN_SPI1_SSEL
  } pmx_func_e;

  localparam int FUNC_COUNT = int'(FN_SPI1_SSEL) + 1;

  // how a pin is driven for a given function
  typedef enum logic [2:0] {
    KIND_GPIO, KIND_IN, KIND_OUT, KIND_BIDIR, KIND_OPEN_DRAIN
  } pmx_kind_e;

  // pad drive pair
  typedef struct packed {
    logic level;
    logic enable;
  } pmx_drive_s;

  // register port request
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } pmx_req_s;

  // direction class of each function
  function automatic pmx_kind_e func_kind(input pmx_func_e f);
    case (f)
      FN_GPIO: func_kind = KIND_GPIO;
      FN_U0_TXD, FN_U1_TXD, FN_U1_RTS, FN_U1_DTR,
      FN_PWM1, FN_PWM2, FN_PWM3, FN_PWM4, FN_PWM5, FN_PWM6,
      FN_T0_MAT0, FN_T0_MAT1, FN_T0_MAT2,
      FN_T1_MAT0, FN_T1_MAT1, FN_T1_MAT2, FN_T1_MAT3: func_kind = KIND_OUT;
      FN_SPI0_SCK, FN_SPI0_MISO, FN_SPI0_MOSI, FN_SPI0_SSEL,
      FN_SPI1_SCK, FN_SPI1_MISO, FN_SPI1_MOSI, FN_SPI1_SSEL: func_kind = KIND_BIDIR;
      FN_I2C_SCL, FN_I2C_SDA: func_kind = KIND_OPEN_DRAIN;
      default: func_kind = KIND_IN;
    endcase
  endfunction : func_kind

endpackage : pmx_pkg

// ### src/pmx_regs.sv
// pmx_regs: the three select registers behind the plain register port.
// assumes one-cycle strobes, never read and write together.
`timescale 1ns/1ps
module pmx_regs (
  // clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rst,
  // register port
  input  wire pmx_pkg::pmx_req_s req,
  output logic [31:0]            rd_data,
  // select register contents
  output logic [31:0]            sel_low,
  output logic [31:0]            sel_high,
  output logic [31:0]            sel_bus
);
  import pmx_pkg::*;

  // writes store the whole word at the decoded address
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sel_low  <= RST_SEL_LOW;
      sel_high <= RST_SEL_HIGH;
      sel_bus  <= RST_SEL_BUS;
    end else if (req.wr) begin
      if (req.addr == ADDR_SEL_LOW)  sel_low  <= req.wdata;
      if (req.addr == ADDR_SEL_HIGH) sel_high <= req.wdata;
      if (req.addr == ADDR_SEL_BUS)  sel_bus  <= req.wdata;
    end
  end

  // read data stand in the cycle after the strobe
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rd_data <= RD_UNMAPPED;
    end else if (req.rd) begin
      case (req.addr)
        ADDR_SEL_LOW:  rd_data <= sel_low;
        ADDR_SEL_HIGH: rd_data <= sel_high;
        ADDR_SEL_BUS:  rd_data <= sel_bus;
        default:       rd_data <= RD_UNMAPPED;
      endcase
    end else begin
      rd_data <= RD_UNMAPPED;
    end
  end

endmodule : pmx_regs

// ### src/pmx_pin_cell.sv
// pmx_pin_cell: output side of one pad, registered level and enable.
// assumes function selection settles one cycle before use.
`timescale 1ns/1ps
module pmx_pin_cell #(
  parameter int NF = pmx_pkg::FUNC_COUNT
) (
  // clock and reset
  input  wire logic                sys_clk,
  input  wire logic                rst,
  // selection and sources
  input  wire pmx_pkg::pmx_func_e  func,
  input  wire logic                gpio_out,
  input  wire logic                gpio_dir,
  input  wire logic [NF-1:0]       periph_out,
  input  wire logic [NF-1:0]       periph_oe,
  // pad drive
  output pmx_pkg::pmx_drive_s      drive
);
  import pmx_pkg::*;

  // pick level and enable by the selected function's direction class
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      drive <= '0;
    end else begin
      case (func_kind(func))
        KIND_GPIO: begin
          drive.level  <= gpio_out;
          drive.enable <= gpio_dir;
        end
        KIND_OUT: begin
          drive.level  <= periph_out[func];
          drive.enable <= 1'b1;
        end
        KIND_BIDIR: begin
          drive.level  <= periph_out[func];
          drive.enable <= periph_oe[func];
        end
        KIND_OPEN_DRAIN: begin
          drive.level  <= 1'b0;
          drive.enable <= ~periph_out[func];
        end
        default: begin
          drive.level  <= 1'b0; // inputs and reserved codes never drive
          drive.enable <= 1'b0;
        end
      endcase
    end
  end

endmodule : pmx_pin_cell

// ### src/pmx_top.sv
// pmx_top: port-0 pin function mux for pins 0 to 22.
// assumes peripherals present per-function out/oe vectors and take inputs back.
//
// Notes on behaviour
// - each pin muxed to gpio or peripheral
// - three read/write select registers at fixed addresses
// - two-bit field per pin, 00 gpio, reset 00
// - unmapped enabled peripheral sees undefined input; here an unmapped peripheral input reads 0
// - gpio direction only when gpio selected
// - pins 0 to 2 function table
// - pins 3 and 4 function table
// - pins 5 to 7 function table
// - pins 8 to 10 function table
// - pins 11 to 15 function table
// - pins 16 to 18 function table
// - pins 19 to 22 function table
`timescale 1ns/1ps
module pmx_top (
  // clock and reset
  input  wire logic                             sys_clk,
  input  wire logic                             rst,
  // register port
  input  wire pmx_pkg::pmx_req_s                req,
  output logic [31:0]                           rd_data,
  // gpio port side
  input  wire logic [pmx_pkg::PIN_COUNT-1:0]    gpio_out,
  input  wire logic [pmx_pkg::PIN_COUNT-1:0]    gpio_dir,
  output logic [pmx_pkg::PIN_COUNT-1:0]         gpio_in,
  // peripheral side, indexed by function
  input  wire logic [pmx_pkg::FUNC_COUNT-1:0]   periph_out,
  input  wire logic [pmx_pkg::FUNC_COUNT-1:0]   periph_oe,
  output logic [pmx_pkg::FUNC_COUNT-1:0]        periph_in,
  // pads
  input  wire logic [pmx_pkg::PIN_COUNT-1:0]    pad_in,
  output logic [pmx_pkg::PIN_COUNT-1:0]         pad_out,
  output logic [pmx_pkg::PIN_COUNT-1:0]         pad_oe
);
  import pmx_pkg::*;

  logic [31:0]           sel_low;
  logic [31:0]           sel_high;
  logic [31:0]           sel_bus;
  pmx_func_e             pin_func [PIN_COUNT];
  pmx_drive_s            drive    [PIN_COUNT];
  logic [FUNC_COUNT-1:0] next_periph_in;

  // choose among the three alternates of a pin
  function automatic pmx_func_e pick(input logic [1:0] code, input pmx_func_e f1,
                                     input pmx_func_e f2, input pmx_func_e f3);
    case (code)
      CODE_ALT1: pick = f1;
      CODE_ALT2: pick = f2;
      CODE_ALT3: pick = f3;
      default:   pick = FN_GPIO;
    endcase
  endfunction : pick

  // function table of port-0 pins 0 to 22
  function automatic pmx_func_e func_of(input int pin, input logic [1:0] code);
    case (pin)
      0:  func_of = pick(code, FN_U0_TXD,    FN_PWM1,      FN_RESERVED);
      1:  func_of = pick(code, FN_U0_RXD,    FN_PWM3,      FN_EXT_INT0);
      2:  func_of = pick(code, FN_I2C_SCL,   FN_T0_CAP0,   FN_RESERVED);
      3:  func_of = pick(code, FN_I2C_SDA,   FN_T0_MAT0,   FN_EXT_INT1);
      4:  func_of = pick(code, FN_SPI0_SCK,  FN_T0_CAP1,   FN_RESERVED);
      5:  func_of = pick(code, FN_SPI0_MISO, FN_T0_MAT1,   FN_RESERVED);
      6:  func_of = pick(code, FN_SPI0_MOSI, FN_T0_CAP2,   FN_RESERVED);
      7:  func_of = pick(code, FN_SPI0_SSEL, FN_PWM2,      FN_EXT_INT2);
      8:  func_of = pick(code, FN_U1_TXD,    FN_PWM4,      FN_RESERVED);
      9:  func_of = pick(code, FN_U1_RXD,    FN_PWM6,      FN_EXT_INT3);
      10: func_of = pick(code, FN_U1_RTS,    FN_T1_CAP0,   FN_RESERVED);
      11: func_of = pick(code, FN_U1_CTS,    FN_T1_CAP1,   FN_RESERVED);
      12: func_of = pick(code, FN_U1_DSR,    FN_T1_MAT0,   FN_RESERVED);
      13: func_of = pick(code, FN_U1_DTR,    FN_T1_MAT1,   FN_RESERVED);
      14: func_of = pick(code, FN_U1_DCD,    FN_EXT_INT1,  FN_RESERVED);
      15: func_of = pick(code, FN_U1_RI,     FN_EXT_INT2,  FN_RESERVED);
      16: func_of = pick(code, FN_EXT_INT0,  FN_T0_MAT2,   FN_T0_CAP2);
      17: func_of = pick(code, FN_T1_CAP2,   FN_SPI1_SCK,  FN_T1_MAT2);
      18: func_of = pick(code, FN_T1_CAP3,   FN_SPI1_MISO, FN_T1_MAT3);
      19: func_of = pick(code, FN_T1_MAT2,   FN_SPI1_MOSI, FN_T1_CAP2);
      20: func_of = pick(code, FN_T1_MAT3,   FN_SPI1_SSEL, FN_EXT_INT3);
      21: func_of = pick(code, FN_PWM5,      FN_RESERVED,  FN_T1_CAP3);
      22: func_of = pick(code, FN_RESERVED,  FN_T0_CAP0,   FN_T0_MAT0);
      default: func_of = FN_RESERVED;
    endcase
  endfunction : func_of

  // select register file
  pmx_regs u_regs (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .req      (req),
    .rd_data  (rd_data),
    .sel_low  (sel_low),
    .sel_high (sel_high),
    .sel_bus  (sel_bus)
  );

  // per-pin field decode and output cell
  genvar gp;
  generate
    for (gp = 0; gp < PIN_COUNT; gp++) begin : g_pin
      localparam int LOW_BIT = FIELD_W * (gp % FIELDS_PER_REG);
      logic [1:0] code;
      // pins 0-15 in the low register, the rest in the high one
      assign code = (gp < FIELDS_PER_REG) ? sel_low[LOW_BIT +: FIELD_W]
                                          : sel_high[LOW_BIT +: FIELD_W];
      assign pin_func[gp] = func_of(gp, code);

      pmx_pin_cell u_cell (
        .sys_clk    (sys_clk),
        .rst        (rst),
        .func       (pin_func[gp]),
        .gpio_out   (gpio_out[gp]),
        .gpio_dir   (gpio_dir[gp]),
        .periph_out (periph_out),
        .periph_oe  (periph_oe),
        .drive      (drive[gp])
      );
      // pad pins straight from the cell flops
      assign pad_out[gp] = drive[gp].level;
      assign pad_oe[gp]  = drive[gp].enable;
    end
  endgenerate

  // route pads back to peripherals; lowest mapped pin wins, unmapped reads 0
  always_comb begin
    next_periph_in = '0;
    for (int p = PIN_COUNT - 1; p >= 0; p--) begin
      if (pin_func[p] != FN_GPIO && pin_func[p] != FN_RESERVED) begin
        next_periph_in[pin_func[p]] = pad_in[p];
      end
    end
  end

  // registered peripheral inputs
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      periph_in <= '0;
    end else begin
      periph_in <= next_periph_in;
    end
  end

  // gpio always sees the pad level, whatever is selected
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      gpio_in <= '0;
    end else begin
      gpio_in <= pad_in;
    end
  end

endmodule : pmx_top

// ### test/pmx_top_asserts.sv
// pmx_top_asserts: port checks for the pin function mux.
// assumes bind onto pmx_top; shadows the low select register.
`timescale 1ns/1ps
module pmx_top_asserts (
  // clock and reset
  input wire logic                              sys_clk,
  input wire logic                              rst,
  // register port
  input wire pmx_pkg::pmx_req_s                 req,
  input wire logic [31:0]                       rd_data,
  // gpio side
  input wire logic [pmx_pkg::PIN_COUNT-1:0]     gpio_out,
  input wire logic [pmx_pkg::PIN_COUNT-1:0]     gpio_dir,
  input wire logic [pmx_pkg::PIN_COUNT-1:0]     gpio_in,
  // peripheral side
  input wire logic [pmx_pkg::FUNC_COUNT-1:0]    periph_out,
  input wire logic [pmx_pkg::FUNC_COUNT-1:0]    periph_oe,
  input wire logic [pmx_pkg::FUNC_COUNT-1:0]    periph_in,
  // pads
  input wire logic [pmx_pkg::PIN_COUNT-1:0]     pad_in,
  input wire logic [pmx_pkg::PIN_COUNT-1:0]     pad_out,
  input wire logic [pmx_pkg::PIN_COUNT-1:0]     pad_oe
);
  import pmx_pkg::*;
  logic [31:0] shadow;
  logic        armed;
  // shadow of the low register, and a flag set one edge past reset
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      shadow <= 32'h0;
      armed  <= 1'b0;
    end else begin
      armed <= 1'b1;
      if (req.wr && req.addr == ADDR_SEL_LOW) shadow <= req.wdata;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_gpio_in_pad: assert property (armed |-> gpio_in == $past(pad_in))
    else $error("gpio input not the last pad level");
  a_read_idle_zero: assert property (armed && !$past(req.rd) |-> rd_data == 32'h0)
    else $error("read data not zero when idle");
  a_low_read_back: assert property (req.rd && req.addr == ADDR_SEL_LOW |=> rd_data == shadow)
    else $error("low register read differs from last write");
  a_gpio_dir_pin0: assert property (armed && $past(shadow[1:0]) == CODE_GPIO |->
    pad_oe[0] == $past(gpio_dir[0]) && (!pad_oe[0] || pad_out[0] == $past(gpio_out[0])))
    else $error("pin 0 gpio drive wrong");
  a_uart_tx_pin0: assert property (armed && $past(shadow[1:0]) == CODE_ALT1 |->
    pad_oe[0] && pad_out[0] == $past(periph_out[FN_U0_TXD])) else $error("pin 0 uart drive wrong");
  a_reserved_pin0: assert property (armed && $past(shadow[1:0]) == CODE_ALT3 |-> !pad_oe[0] && !pad_out[0])
    else $error("pin 0 driven under reserved code");
  a_ext_int_pin1: assert property (armed && $past(shadow[3:2]) == CODE_ALT3 |->
    periph_in[FN_EXT_INT0] == $past(pad_in[1]) && !pad_oe[1]) else $error("pin 1 interrupt input wrong");
  a_unmapped_zero: assert property (armed && $past(shadow[3:2]) != CODE_ALT1 |-> !periph_in[FN_U0_RXD])
    else $error("unmapped uart input not zero");
endmodule : pmx_top_asserts

bind pmx_top pmx_top_asserts u_pmx_top_asserts (.sys_clk(sys_clk), .rst(rst), .req(req), .rd_data(rd_data),
  .gpio_out(gpio_out), .gpio_dir(gpio_dir), .gpio_in(gpio_in), .periph_out(periph_out), .periph_oe(periph_oe),
  .periph_in(periph_in), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe));

// ### test/pmx_far_model.sv
// pmx_far_model: the pads and the board beyond the pin mux.
// assumes the bench sets the board level of every pad left undriven.
`timescale 1ns/1ps
module pmx_far_model (
  // pad side of the mux
  input  wire logic [pmx_pkg::PIN_COUNT-1:0] pad_out,
  input  wire logic [pmx_pkg::PIN_COUNT-1:0] pad_oe,
  output logic      [pmx_pkg::PIN_COUNT-1:0] pad_in,
  // board level on pads the chip leaves alone
  input  wire logic [pmx_pkg::PIN_COUNT-1:0] ext_level
);
  import pmx_pkg::*;
  // a driven pad reads back its own level, otherwise the board level
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_level);
endmodule : pmx_far_model

// ### test/pmx_top_tb.sv
// pmx_top_tb: register and pad checks for the port-0 pin mux.
// assumes the far model closes the pad loop; one 250 MHz clock.
`timescale 1ns/1ps
module pmx_top_tb;
  import pmx_pkg::*;
  logic                  sys_clk = 1'b0;
  logic                  rst = 1'b1;
  pmx_req_s              req = '0;
  logic [31:0]           rd_data;
  logic [PIN_COUNT-1:0]  gpio_out = '0, gpio_dir = '0, ext = '0, gpio_in, pad_in, pad_out, pad_oe;
  logic [FUNC_COUNT-1:0] periph_out = '0, periph_oe = '0, periph_in;
  int                    n_fail = 0, samples_checked = 0;
  int                    tp[7] = '{3, 5, 8, 12, 13, 19, 21};
  int                    tc[7] = '{2, 2, 1, 2, 1, 1, 1};
  pmx_func_e             tf[7] = '{FN_T0_MAT0, FN_T0_MAT1, FN_U1_TXD, FN_T1_MAT0, FN_U1_DTR, FN_T1_MAT2, FN_PWM5};
  always #2 sys_clk = ~sys_clk;
  pmx_top u_pmx_top (.sys_clk(sys_clk), .rst(rst), .req(req), .rd_data(rd_data), .gpio_out(gpio_out),
    .gpio_dir(gpio_dir), .gpio_in(gpio_in), .periph_out(periph_out), .periph_oe(periph_oe),
    .periph_in(periph_in), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe));
  pmx_far_model u_pmx_far_model (.pad_out(pad_out), .pad_oe(pad_oe), .pad_in(pad_in), .ext_level(ext));
  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // one-cycle write strobe
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    req.wr <= 1'b0;
  endtask : wr
  // one-cycle read strobe, data looked at in the following cycle
  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    @(posedge sys_clk);
    req.addr <= a;
    req.rd   <= 1'b1;
    @(posedge sys_clk);
    req.rd <= 1'b0;
    #1 chk(rd_data, exp);
  endtask : rd
  // let a selection reach the pads
  task automatic settle;
    repeat (2) @(posedge sys_clk);
    #1;
  endtask : settle
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish
  // cut a hang short
  initial begin
    repeat (5000) @(posedge sys_clk);
    n_fail++;
    tally_and_finish();
  end
  initial begin
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    // reset values, unmapped place, read back
    rd(ADDR_SEL_LOW, RST_SEL_LOW);
    rd(ADDR_SEL_HIGH, RST_SEL_HIGH);
    rd(ADDR_SEL_BUS, RST_SEL_BUS);
    wr(ADDR_SEL_BUS, 32'h0f0fa5a5);
    wr(32'he002c008, 32'hffffffff);
    rd(32'he002c008, RD_UNMAPPED);
    rd(ADDR_SEL_BUS, 32'h0f0fa5a5);
    wr(ADDR_SEL_HIGH, 32'h5a5a0003);
    rd(ADDR_SEL_HIGH, 32'h5a5a0003);
    $display("registers done");
    // pin 0: each source under each code, code 11 reserved on purpose
    for (int s = 0; s < 3; s++) begin
      @(posedge sys_clk);
      gpio_out[0] <= (s == 0);
      gpio_dir[0] <= (s != 1);
      periph_out[FN_U0_TXD] <= (s == 1);
      periph_out[FN_PWM1] <= (s == 2);
      for (int c = 0; c < 4; c++) begin
        wr(ADDR_SEL_LOW, 32'(c));
        settle();
        chk(pad_out[0], c == s);
        chk(pad_oe[0], c == 0 ? s != 1 : c != 3);
      end
    end
    $display("pin 0 done");
    // interrupt 0 on pins 1 and 16: the lower pin feeds it
    @(posedge sys_clk);
    ext[1] <= 1'b1;
    wr(ADDR_SEL_LOW, 32'h0000000c);
    wr(ADDR_SEL_HIGH, 32'h00000001);
    settle();
    chk(periph_in[FN_EXT_INT0], 1'b1);
    chk(periph_in[FN_U0_RXD], 1'b0);
    chk({gpio_in[1], pad_oe[16]}, 2'b10);
    // pin 1 low and pin 16 high: only pin 16 may feed the interrupt now
    @(posedge sys_clk);
    ext <= 23'h010000;
    wr(ADDR_SEL_LOW, 32'h0);
    settle();
    chk(periph_in[FN_EXT_INT0], 1'b1);
    $display("inputs done");
    // output functions across the tables, one pin at a time
    for (int i = 0; i < 7; i++) begin
      @(posedge sys_clk);
      periph_out <= {{(FUNC_COUNT-1){1'b0}}, 1'b1} << tf[i];
      wr(tp[i] < 16 ? ADDR_SEL_LOW : ADDR_SEL_HIGH, 32'(tc[i]) << (2 * (tp[i] % 16)));
      settle();
      chk({pad_oe[tp[i]], pad_out[tp[i]]}, 2'b11);
    end
    $display("outputs done");
    // spi clock drives only when enabled; pin 21 code 10 is reserved
    @(posedge sys_clk);
    gpio_dir <= '1;
    gpio_out <= '1;
    periph_out <= '0;
    wr(ADDR_SEL_HIGH, 32'h00000808);
    settle();
    chk({pad_oe[17], pad_oe[21], pad_out[21]}, 3'b000);
    @(posedge sys_clk);
    periph_oe[FN_SPI1_SCK] <= 1'b1;
    settle();
    chk({pad_oe[17], pad_out[17], pad_oe[5]}, 3'b101);
    // open-drain clock on pin 2: pulls low only, floats to the board level
    @(posedge sys_clk);
    ext <= 23'h000004;
    wr(ADDR_SEL_LOW, 32'h00000010);
    settle();
    chk({pad_oe[2], pad_out[2], periph_in[FN_I2C_SCL]}, 3'b100);
    @(posedge sys_clk);
    periph_out[FN_I2C_SCL] <= 1'b1;
    settle();
    chk({pad_oe[2], pad_out[2], periph_in[FN_I2C_SCL]}, 3'b001);
    // second reset clears the selection
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    rd(ADDR_SEL_HIGH, RST_SEL_HIGH);
    chk({pad_oe[17], pad_out[17]}, 2'b11);
    $display("direction and reset done");
    tally_and_finish();
  end
endmodule : pmx_top_tb
